// ---- bench/an_engine_model.sv ----
// Negotiation engine stand-in: turns bench requests into engine pulses.
// Assumes the bench raises each request for one cycle only.
`timescale 1ns/1ps
module an_engine_model (
   // Clock
   input wire logic core_clk,
   // Requests from the bench
   input wire autoneg_regs_pkg::anEvents_t evReq,
   input wire logic rxReq,
   input wire logic [15:0] pageReq,
   // Engine outputs
   output autoneg_regs_pkg::anEvents_t anEvents,
   output logic rxErrFrame,
   output logic [15:0] partnerPage
);
   // One-cycle pulses; page word only meaningful with the page pulse
   always_ff @(posedge core_clk) begin
      anEvents <= evReq;
      rxErrFrame <= rxReq;
      partnerPage <= evReq.pageRcv ? pageReq : ~pageReq;
   end
endmodule : an_engine_model

// ---- bench/autoneg_page_status_registers_tb.sv ----
// Self-checking bench for the auto-negotiation page and status registers.
// Assumes the register package and the engine stand-in are compiled first.
`timescale 1ns/1ps
module autoneg_page_status_registers_tb;
   logic core_clk, nrst, regRead, regWrite, regRvalid, intOut, rxReq, rxErrFrame;
   logic [4:0] regAddr;
   logic [15:0] regWdata, regRdata, pageReq, partnerPage;
   autoneg_regs_pkg::anStatus_t anStatus;
   autoneg_regs_pkg::anEvents_t anEvents, evReq;
   autoneg_regs_pkg::localPage_t localPage;
   int numErrors = 0;
   int testsRun = 0;
   localparam logic [4:0] RST_ADR [7] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h15, 5'h1B, 5'h00};
   localparam logic [15:0] RST_VAL [7] = '{16'h0001, 16'h0004, 16'h2001, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};

   autoneg_page_status_registers autoneg_page_status_registers_i (
      .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regRead(regRead),
      .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
      .regRvalid(regRvalid), .anStatus(anStatus), .anEvents(anEvents),
      .partnerPage(partnerPage), .rxErrFrame(rxErrFrame), .localPage(localPage),
      .intOut(intOut));

   an_engine_model an_engine_model_i (
      .core_clk(core_clk), .evReq(evReq), .rxReq(rxReq), .pageReq(pageReq),
      .anEvents(anEvents), .rxErrFrame(rxErrFrame), .partnerPage(partnerPage));

   // Clock, 4 ns period
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Expected register images
   function automatic logic [15:0] exp6(autoneg_regs_pkg::anStatus_t s, logic pd, logic pr);
      return {11'h000, pd, s.lpNextPageAble, 1'b1, pr, s.lpAnAble};
   endfunction : exp6
   function automatic logic [15:0] exp7(logic [15:0] w, logic t);
      return {w[15], 1'b0, w[13:12], t, w[10:0]};
   endfunction : exp7

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         numErrors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // Read strobe, answer one cycle later
   task automatic rdReg(input logic [4:0] a, output logic [15:0] d);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      chk({15'h0000, regRvalid}, 16'h0001);
      d = regRdata;
   endtask : rdReg

   task automatic wrReg(input logic [4:0] a, input logic [15:0] w);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= w;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wrReg

   // Engine pulse through the stand-in, then let flags and interrupt settle
   task automatic fire(input autoneg_regs_pkg::anEvents_t e, input logic r,
         input logic [15:0] pg);
      @(posedge core_clk);
      evReq <= e;
      rxReq <= r;
      pageReq <= pg;
      @(posedge core_clk);
      evReq <= '0;
      rxReq <= 1'b0;
      cyc(3);
      #1;
   endtask : fire

   task automatic testDone();
      $display("comparisons %0d mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : testDone

   // Hang guard
   initial begin
      cyc(5000);
      numErrors++;
      $display("BAD %0t run did not finish", $time);
      testDone();
   end

   initial begin
      logic [15:0] d, w, p;
      int n;
      autoneg_regs_pkg::anEvents_t e;
      void'($urandom(32'h61D8));
      nrst = 1'b0;
      regRead = 1'b0;
      regWrite = 1'b0;
      regAddr = 5'h00;
      regWdata = 16'h0000;
      anStatus = '0;
      anStatus.lpSelector = 5'h01; // Idle engine shows the standard selector
      evReq = '0;
      rxReq = 1'b0;
      pageReq = 16'h0000;
      cyc(6);
      nrst <= 1'b1;
      chk({2'b00, localPage}, 16'h1001);
      for (int i = 0; i < 7; i++) begin
         rdReg(RST_ADR[i], d);
         chk(d, RST_VAL[i]);
      end
      $display("reset values done");
      // Random levels, writes to read-only and writable places
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk);
         anStatus <= autoneg_regs_pkg::anStatus_t'(12'($urandom));
         w = 16'($urandom);
         wrReg(5'h05, w);
         wrReg(5'h06, w);
         wrReg(5'h08, w);
         wrReg(5'h07, w);
         wrReg(5'h1B, w);
         rdReg(5'h05, d);
         chk(d, {7'h00, anStatus.lpAbility, anStatus.lpSelector});
         rdReg(5'h06, d);
         chk(d, exp6(anStatus, 1'b0, 1'b0));
         rdReg(5'h07, d);
         chk(d, exp7(w, anStatus.txToggle));
         chk({2'b00, localPage}, {2'b00, w[15], w[13:12], w[10:0]});
         rdReg(5'h08, d);
         chk(d, 16'h0000);
         rdReg(5'h1B, d);
         chk(d, {w[15:11], 11'h000});
      end
      wrReg(5'h1B, 16'h0000);
      $display("levels and writes done");
      // Page and fault flags with interrupts masked
      p = 16'($urandom);
      e = '0;
      e.pageRcv = 1'b1;
      e.pdFault = 1'b1;
      fire(e, 1'b0, p);
      chk({15'h0000, intOut}, 16'h0000);
      rdReg(5'h06, d);
      chk(d, exp6(anStatus, 1'b1, 1'b1));
      rdReg(5'h06, d);
      chk(d, exp6(anStatus, 1'b0, 1'b0));
      rdReg(5'h08, d);
      chk(d, {p[15:12], ~anStatus.txToggle, p[10:0]});
      rdReg(5'h1B, d);
      chk(d, 16'h0030);
      $display("latched flags done");
      // Receive-error frame count
      n = 1 + int'($urandom % 8);
      repeat (n) fire('0, 1'b1, 16'h0000);
      // Frame in the same cycle as the clearing read survives as one
      fork
         fire('0, 1'b1, 16'h0000);
         begin
            @(posedge core_clk);
            rdReg(5'h15, d);
         end
      join
      chk(d, 16'(n));
      rdReg(5'h15, d);
      chk(d, 16'h0001);
      rdReg(5'h15, d);
      chk(d, 16'h0000);
      $display("error counter done");
      // Each interrupt enabled alone, raised and cleared by reading
      for (int i = 0; i < 5; i++) begin
         e = autoneg_regs_pkg::anEvents_t'(5'h01 << i);
         wrReg(5'h1B, {e, 11'h000});
         fire(e, 1'b0, 16'(~p));
         chk({15'h0000, intOut}, 16'h0001);
         rdReg(5'h1B, d);
         chk(d, {e, 3'b000, e, 3'b000});
         cyc(2);
         #1;
         chk({15'h0000, intOut}, 16'h0000);
         rdReg(5'h1B, d);
         chk(d, {e, 11'h000});
      end
      $display("interrupts done");
      testDone();
   end
endmodule : autoneg_page_status_registers_tb

// ---- logic/autoneg_page_status_registers.sv ----
// Auto-negotiation page, expansion, error counter and interrupt registers.
// Assumes a register port with one-cycle read and write strobes, and
// events from the negotiation engine as one-cycle pulses.
// Contract
// - Partner speed and duplex ability bits, read-only, zero after reset.
// - Partner selector field read-only, resets to 00001.
// - Parallel detection fault latches high until read, then clears.
// - Partner next-page able bit follows the partner, resets zero.
// - Local next-page able bit reads one.
// - Page-received flag latches high, clears on read, resets zero.
// - Partner auto-negotiation able bit follows detection, resets zero.
// - Writable next-page flag, one while more pages follow, resets zero.
// - Writable second acknowledge bit, resets zero.
// - Read-only toggle bit mirrors last transmitted toggle, resets zero.
// - Writable 11-bit message field, resets to 001.
// - Received partner page read-only; next-page and message-page bits.
// - Partner acknowledge bit read-only, resets zero.
// - Partner second acknowledge bit read-only, resets zero.
// - Partner toggle bit reads inverted transmitted toggle, resets zero.
// - 16-bit receive-error frame counter, clears when read.
// - Jabber and receive-error interrupt enables, writable, reset zero.
// - Page-received and parallel-fault interrupt enables, reset zero.
// - Partner acknowledge interrupt enable, writable, resets zero.
// - Interrupt status bits set on event, clear on read.
`timescale 1ns/1ps
module autoneg_page_status_registers (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Register port
   input wire logic [4:0] regAddr,
   input wire logic regRead,
   input wire logic regWrite,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   output logic regRvalid,
   // Negotiation engine and receive path
   input wire autoneg_regs_pkg::anStatus_t anStatus,
   input wire autoneg_regs_pkg::anEvents_t anEvents,
   input wire logic [15:0] partnerPage,
   input wire logic rxErrFrame,
   // Outgoing next page and interrupt
   output autoneg_regs_pkg::localPage_t localPage,
   output logic intOut
);

   // Exact register number match, shared by read and write decode
   function automatic logic hitReg(input logic [4:0] addr, input logic [4:0] reg_n);
      hitReg = (addr == reg_n);
   endfunction : hitReg

   logic rdExp;
   logic rdInt;
   logic rdCnt;
   logic wrNp;
   logic wrInt;
   logic [15:0] errCount;

   // Read side effects and write strobes
   assign rdExp = regRead && hitReg(regAddr, autoneg_regs_pkg::ADDR_EXPANSION);
   assign rdInt = regRead && hitReg(regAddr, autoneg_regs_pkg::ADDR_INT_CTRL);
   assign rdCnt = regRead && hitReg(regAddr, autoneg_regs_pkg::ADDR_RXERR_COUNT);
   assign wrNp = regWrite && hitReg(regAddr, autoneg_regs_pkg::ADDR_LOCAL_NP);
   assign wrInt = regWrite && hitReg(regAddr, autoneg_regs_pkg::ADDR_INT_CTRL);

   // Partner status state
   logic [3:0] abil_q, abil_d;
   logic [4:0] sel_q, sel_d;
   logic lpNpAble_q, lpNpAble_d;
   logic lpAnAble_q, lpAnAble_d;
   logic txToggle_q, txToggle_d;
   logic pdFault_q, pdFault_d;
   logic pageRx_q, pageRx_d;
   logic [15:0] rxNp_q, rxNp_d;

   // Partner levels follow the engine; latched flags set-over-clear
   always_comb begin
      abil_d = anStatus.lpAbility;
      sel_d = anStatus.lpSelector;
      lpNpAble_d = anStatus.lpNextPageAble;
      lpAnAble_d = anStatus.lpAnAble;
      txToggle_d = anStatus.txToggle;
      pdFault_d = anEvents.pdFault | (pdFault_q & ~rdExp);
      pageRx_d = anEvents.pageRcv | (pageRx_q & ~rdExp);
      rxNp_d = rxNp_q;
      if (anEvents.pageRcv) begin
         rxNp_d = partnerPage;
         rxNp_d[autoneg_regs_pkg::NP_TOGGLE] = ~anStatus.txToggle;
      end
   end

   // Partner status registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         abil_q <= autoneg_regs_pkg::ABIL_RESET;
         sel_q <= autoneg_regs_pkg::SEL_RESET;
         lpNpAble_q <= 1'b0;
         lpAnAble_q <= 1'b0;
         txToggle_q <= 1'b0;
         pdFault_q <= 1'b0;
         pageRx_q <= 1'b0;
         rxNp_q <= autoneg_regs_pkg::PARTNER_NP_RESET;
      end else begin
         abil_q <= abil_d;
         sel_q <= sel_d;
         lpNpAble_q <= lpNpAble_d;
         lpAnAble_q <= lpAnAble_d;
         txToggle_q <= txToggle_d;
         pdFault_q <= pdFault_d;
         pageRx_q <= pageRx_d;
         rxNp_q <= rxNp_d;
      end
   end

   // Local next-page word state
   autoneg_regs_pkg::localPage_t np_q, np_d;

   // Only the writable fields take write data
   always_comb begin
      np_d = np_q;
      if (wrNp) begin
         np_d.nextPage = regWdata[autoneg_regs_pkg::NP_NEXT];
         np_d.msgPage = regWdata[autoneg_regs_pkg::NP_MSG_PAGE];
         np_d.ack2 = regWdata[autoneg_regs_pkg::NP_ACK2];
         np_d.msg = regWdata[autoneg_regs_pkg::MSG_W-1:0];
      end
   end

   // Local next-page registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         np_q.nextPage <= autoneg_regs_pkg::NP_NEXT_RESET;
         np_q.msgPage <= autoneg_regs_pkg::NP_MP_RESET;
         np_q.ack2 <= autoneg_regs_pkg::NP_ACK2_RESET;
         np_q.msg <= autoneg_regs_pkg::MSG_RESET;
      end else begin
         np_q <= np_d;
      end
   end

   // Interrupt state
   logic [4:0] intEn_q, intEn_d;
   logic [4:0] intSt_q, intSt_d;
   logic intOut_q, intOut_d;

   // Status set wins over the read clear; output from next values
   always_comb begin
      intEn_d = intEn_q;
      if (wrInt) begin
         intEn_d = regWdata[autoneg_regs_pkg::INT_EN_LSB +:
            autoneg_regs_pkg::NUM_INT];
      end
      for (int i = 0; i < autoneg_regs_pkg::NUM_INT; i++) begin
         intSt_d[i] = anEvents[i] | (intSt_q[i] & ~rdInt);
      end
      intOut_d = |(intSt_d & intEn_d);
   end

   // Interrupt registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         intEn_q <= autoneg_regs_pkg::INT_RESET;
         intSt_q <= autoneg_regs_pkg::INT_RESET;
         intOut_q <= 1'b0;
      end else begin
         intEn_q <= intEn_d;
         intSt_q <= intSt_d;
         intOut_q <= intOut_d;
      end
   end

   // Receive-error frames, cleared by the read that returns them
   rx_error_counter errCounter (
      .core_clk(core_clk),
      .nrst(nrst),
      .countEvt(rxErrFrame),
      .clearRd(rdCnt),
      .count(errCount)
   );

   // Read data assembly; unlisted bits and registers read zero
   logic [15:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;

   always_comb begin
      rdata_d = 16'h0000;
      rvalid_d = regRead;
      if (!regRead) begin
         rdata_d = rdata_q;
      end else if (hitReg(regAddr, autoneg_regs_pkg::ADDR_PARTNER_BASE)) begin
         rdata_d[autoneg_regs_pkg::ABIL_LSB +: 4] = abil_q;
         rdata_d[autoneg_regs_pkg::SEL_LSB +: 5] = sel_q;
      end else if (hitReg(regAddr, autoneg_regs_pkg::ADDR_EXPANSION)) begin
         rdata_d[autoneg_regs_pkg::EXP_PD_FAULT] = pdFault_q;
         rdata_d[autoneg_regs_pkg::EXP_LP_NP_ABLE] = lpNpAble_q;
         rdata_d[autoneg_regs_pkg::EXP_NP_ABLE] = autoneg_regs_pkg::LOCAL_NP_ABLE;
         rdata_d[autoneg_regs_pkg::EXP_PAGE_RX] = pageRx_q;
         rdata_d[autoneg_regs_pkg::EXP_LP_AN_ABLE] = lpAnAble_q;
      end else if (hitReg(regAddr, autoneg_regs_pkg::ADDR_LOCAL_NP)) begin
         rdata_d[autoneg_regs_pkg::NP_NEXT] = np_q.nextPage;
         rdata_d[autoneg_regs_pkg::NP_MSG_PAGE] = np_q.msgPage;
         rdata_d[autoneg_regs_pkg::NP_ACK2] = np_q.ack2;
         rdata_d[autoneg_regs_pkg::NP_TOGGLE] = txToggle_q;
         rdata_d[autoneg_regs_pkg::MSG_W-1:0] = np_q.msg;
      end else if (hitReg(regAddr, autoneg_regs_pkg::ADDR_PARTNER_NP)) begin
         rdata_d = rxNp_q;
      end else if (hitReg(regAddr, autoneg_regs_pkg::ADDR_RXERR_COUNT)) begin
         rdata_d = errCount;
      end else if (hitReg(regAddr, autoneg_regs_pkg::ADDR_INT_CTRL)) begin
         rdata_d[autoneg_regs_pkg::INT_EN_LSB +: autoneg_regs_pkg::NUM_INT] = intEn_q;
         rdata_d[autoneg_regs_pkg::INT_ST_LSB +: autoneg_regs_pkg::NUM_INT] = intSt_q;
      end
   end

   // Read data registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign regRdata = rdata_q;
   assign regRvalid = rvalid_q;
   assign localPage = np_q;
   assign intOut = intOut_q;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence sReadExp;
      regRead && regAddr == autoneg_regs_pkg::ADDR_EXPANSION;
   endsequence

   sequence sReadInt;
      regRead && regAddr == autoneg_regs_pkg::ADDR_INT_CTRL;
   endsequence

   // Fault pulse followed by two cycles with no read strobe
   sequence sFaultQuiet;
      anEvents.pdFault ##1 (!regRead)[*2];
   endsequence

   a_pd_fault_latch: assert property (
      sFaultQuiet |-> pdFault_q)
      else $error("parallel fault flag not held");

   // After a read only an event of the read cycle keeps a flag set
   a_pd_fault_clear: assert property (
      sReadExp |=> pdFault_q == $past(anEvents.pdFault))
      else $error("parallel fault flag not cleared by read");

   a_page_rx_clear: assert property (
      sReadExp |=> pageRx_q == $past(anEvents.pageRcv))
      else $error("page received flag not cleared by read");

   a_exp_read_word: assert property (
      sReadExp |=> regRvalid && regRdata[15:5] == 11'h000 && regRdata[2])
      else $error("expansion read shows wrong fixed bits");

   a_partner_toggle: assert property (
      anEvents.pageRcv |=> rxNp_q[autoneg_regs_pkg::NP_TOGGLE] == !$past(anStatus.txToggle))
      else $error("partner toggle not inverted");

   a_np_write: assert property (
      wrNp |=> np_q.msg == $past(regWdata[10:0]) && np_q.nextPage == $past(regWdata[15]))
      else $error("next page write lost");

   a_status_clear: assert property (
      sReadInt |=> intSt_q == $past(anEvents))
      else $error("status not cleared by read");

   // Output may drop only after a status read or an enable write
   a_int_raise: assert property (
      anEvents.jabber && intEn_q[4] && !wrInt
         |=> intOut ##1 (intOut || $past(rdInt) || $past(wrInt)))
      else $error("interrupt output not raised");

   a_count_clear: assert property (
      rdCnt && !rxErrFrame |=> errCount == 16'h0000)
      else $error("error counter not cleared by read");

   a_count_step: assert property (
      rxErrFrame && !rdCnt && errCount != autoneg_regs_pkg::RXERR_MAX
         |=> errCount == $past(errCount) + 16'h0001)
      else $error("error counter missed a frame");

   // Partner levels appear one cycle after the engine drives them
   a_level_track: assert property (
      $past(nrst) |-> abil_q == $past(anStatus.lpAbility)
         && sel_q == $past(anStatus.lpSelector)
         && lpNpAble_q == $past(anStatus.lpNextPageAble)
         && lpAnAble_q == $past(anStatus.lpAnAble)
         && txToggle_q == $past(anStatus.txToggle))
      else $error("partner level register lags wrong");

   // Reset values at the first edge after release
   a_reset_values: assert property (
      $rose(nrst) |-> abil_q == autoneg_regs_pkg::ABIL_RESET
         && sel_q == autoneg_regs_pkg::SEL_RESET
         && np_q.nextPage == autoneg_regs_pkg::NP_NEXT_RESET
         && np_q.msgPage == autoneg_regs_pkg::NP_MP_RESET
         && np_q.ack2 == autoneg_regs_pkg::NP_ACK2_RESET
         && np_q.msg == autoneg_regs_pkg::MSG_RESET && !intOut && !regRvalid)
      else $error("register not at reset value after release");

   a_enable_write: assert property (
      wrInt |=> intEn_q == $past(regWdata[autoneg_regs_pkg::INT_EN_LSB +: 5]))
      else $error("interrupt enable write lost");

   // Writes to the received page word leave it alone
   a_ro_write_ignored: assert property (
      regWrite && regAddr == autoneg_regs_pkg::ADDR_PARTNER_NP && !anEvents.pageRcv
         |=> $stable(rxNp_q))
      else $error("read-only page word changed by write");

   a_read_answer: assert property (
      regRvalid == $past(regRead))
      else $error("read answer not one cycle after strobe");

endmodule : autoneg_page_status_registers

// ---- logic/autoneg_regs_pkg.sv ----
// Constants, field positions and carrier types for the auto-negotiation
// page and status register slice.
// Assumes the register port gives 5-bit register numbers and 16-bit data.
package autoneg_regs_pkg;

   // Register numbers on the register port
   localparam logic [4:0] ADDR_PARTNER_BASE = 5'h05;
   localparam logic [4:0] ADDR_EXPANSION = 5'h06;
   localparam logic [4:0] ADDR_LOCAL_NP = 5'h07;
   localparam logic [4:0] ADDR_PARTNER_NP = 5'h08;
   localparam logic [4:0] ADDR_RXERR_COUNT = 5'h15;
   localparam logic [4:0] ADDR_INT_CTRL = 5'h1B;

   // Partner base ability fields
   localparam int ABIL_LSB = 5;
   localparam int SEL_LSB = 0;
   localparam logic [3:0] ABIL_RESET = 4'h0;
   localparam logic [4:0] SEL_RESET = 5'h01;

   // Expansion fields
   localparam int EXP_PD_FAULT = 4;
   localparam int EXP_LP_NP_ABLE = 3;
   localparam int EXP_NP_ABLE = 2;
   localparam int EXP_PAGE_RX = 1;
   localparam int EXP_LP_AN_ABLE = 0;
   localparam logic LOCAL_NP_ABLE = 1'b1;

   // Next-page word fields, shared by local and partner words
   localparam int NP_NEXT = 15;
   localparam int NP_ACK = 14;
   localparam int NP_MSG_PAGE = 13;
   localparam int NP_ACK2 = 12;
   localparam int NP_TOGGLE = 11;
   localparam int NP_MSG_LSB = 0;
   localparam int MSG_W = 11;
   localparam logic [10:0] MSG_RESET = 11'h001;
   localparam logic NP_NEXT_RESET = 1'b0;
   localparam logic NP_MP_RESET = 1'b1;
   localparam logic NP_ACK2_RESET = 1'b0;
   localparam logic [15:0] PARTNER_NP_RESET = 16'h0000;

   // Interrupt control/status: enables at [15:11], status at [7:3]
   localparam int INT_EN_LSB = 11;
   localparam int INT_ST_LSB = 3;
   localparam int NUM_INT = 5;
   localparam logic [4:0] INT_RESET = 5'h00;

   // Receive-error counter
   localparam logic [15:0] RXERR_RESET = 16'h0000;
   localparam logic [15:0] RXERR_MAX = 16'hFFFF;

   // Interrupt events; order matches enable and status bit order
   typedef struct packed {
      logic jabber;
      logic rxErr;
      logic pageRcv;
      logic pdFault;
      logic lpAck;
   } anEvents_t;

   // Levels from the auto-negotiation engine
   typedef struct packed {
      logic [3:0] lpAbility;   // 100FD, 100HD, 10FD, 10HD
      logic [4:0] lpSelector;
      logic lpNextPageAble;
      logic lpAnAble;
      logic txToggle;          // Toggle of last transmitted code word
   } anStatus_t;

   // Outgoing next page as seen by the engine
   typedef struct packed {
      logic nextPage;
      logic msgPage;
      logic ack2;
      logic [10:0] msg;
   } localPage_t;

endpackage : autoneg_regs_pkg

// ---- logic/rx_error_counter.sv ----
// Saturating receive-error frame counter, cleared when read.
// Assumes one-cycle pulses for a counted frame and for the read.
`timescale 1ns/1ps
module rx_error_counter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Control
   input wire logic countEvt,
   input wire logic clearRd,
   // Count
   output logic [15:0] count
);

   logic [15:0] count_q;
   logic [15:0] count_d;

   // A frame in the read cycle survives as a count of one
   always_comb begin
      count_d = count_q;
      if (clearRd) begin
         count_d = countEvt ? 16'h0001 : autoneg_regs_pkg::RXERR_RESET;
      end else if (countEvt && count_q != autoneg_regs_pkg::RXERR_MAX) begin
         count_d = count_q + 16'h0001;
      end
   end

   // Counter state
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= autoneg_regs_pkg::RXERR_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   assign count = count_q;

endmodule : rx_error_counter
